// File: ebwd_top.sv
// external bus window decoder and external bus controller
`timescale 1ns/1ns
`include "ebwd_params.svh"
module ebwd_top #(
  parameter logic [7:0] REF_HALF = 8'h01,
  parameter logic [15:0] TRAP_CODE = 16'h0001,
  parameter logic [23:0] FLASHREG_TOP = 24'hfff0ff
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // processor request
  input wire logic reqValid,
  input wire logic [`EBWD_AW-1:0] reqAddr,
  input wire logic reqWrite,
  input wire logic reqByte,
  input wire logic reqPeriph,
  input wire logic [`EBWD_DW-1:0] reqWdata,
  output logic reqReady,
  // processor answer
  output logic respValid,
  output logic respTrap,
  output logic [`EBWD_DW-1:0] respRdata,
  // internal memories
  output logic intReqValid,
  output ebwd_pkg::ebwd_region_e intRegion,
  output logic [`EBWD_AW-1:0] intAddr,
  output logic intWrite,
  output logic intByte,
  output logic [`EBWD_DW-1:0] intWdata,
  input wire logic intRespValid,
  input wire logic [`EBWD_DW-1:0] intRdata,
  // internal peripheral bus
  output logic periphSel,
  input wire logic [`EBWD_DW-1:0] periphRdata,
  // configuration
  input wire logic singleChipMode,
  input wire logic [2:0] segLines,
  input wire logic [`EBWD_NWIN-1:0] winEnable,
  input wire logic [`EBWD_NWIN-1:0][`EBWD_WR_W-1:0] winRange,
  input wire logic [`EBWD_NSET-1:0][`EBWD_FC_W-1:0] funcCfg,
  input wire logic [`EBWD_NSET-1:0][`EBWD_TC_W-1:0] timeCfg,
  // status
  output logic [2:0] activeWin,
  output logic ioOrdered,
  // bus pins
  output logic refClkOut,
  output logic ale,
  output logic rdN,
  output logic wrN,
  output logic bheN,
  output logic [3:0] csN,
  input wire logic [`EBWD_DW-1:0] firstPortIn,
  output logic [`EBWD_DW-1:0] firstPortOut,
  output logic [1:0] firstPortOe,
  output logic [`EBWD_DW-1:0] secondPortOut,
  output logic [`EBWD_SEG_W-1:0] segOut,
  input wire logic extReadyN
);
  typedef enum {ST_IDLE, ST_INT, ST_ADDR, ST_ALE, ST_STROBE, ST_HOLD}
    ebwd_state_e;

  function automatic logic [3:0] csFor(input logic [2:0] w);
    logic [3:0] cs;
    cs = `EBWD_CS_IDLE;
    if (w < 3'h4) cs[w[1:0]] = 1'b0;
    return cs;
  endfunction

  function automatic logic [`EBWD_SEG_W-1:0] segMask(input logic [2:0] n);
    logic [7:0] m;
    m = (8'h01 << n) - 8'h01;
    return m[`EBWD_SEG_W-1:0];
  endfunction

  ebwd_state_e state_reg, state_next;
  logic reqReady_reg, respValid_reg, respTrap_reg, intReqValid_reg;
  logic [`EBWD_DW-1:0] respRdata_reg, busRdata_reg;
  logic [`EBWD_AW-1:0] curAddr_reg;
  logic curWrite_reg, curByte_reg, curPeriph_reg, curSingle_reg;
  logic curRdyEn_reg, curPosted_reg, curSecond_reg;
  logic [`EBWD_DW-1:0] curWdata_reg;
  ebwd_pkg::ebwd_region_e curRegion_reg;
  ebwd_pkg::ebwd_mode_e curMode_reg;
  logic [2:0] curWin_reg, activeWin_reg;
  logic [`EBWD_TC_W-1:0] curWaits_reg, waitCnt_reg;
  logic periphSel_reg, ioOrdered_reg;
  logic [7:0] divCnt_reg;
  logic refClk_reg, ale_reg, rdN_reg, wrN_reg, bheN_reg;
  logic [3:0] csN_reg;
  logic [`EBWD_DW-1:0] firstPortOut_reg, secondPortOut_reg;
  logic [1:0] firstPortOe_reg;
  logic [`EBWD_SEG_W-1:0] segOut_reg;
  logic [`EBWD_DW-1:0] portMeta_reg, portSync_reg;
  logic readyMeta_reg, readyNSync_reg;

  ebwd_dec_if decIf();
  assign decIf.addr = reqAddr;
  assign decIf.winEnable = winEnable;
  assign decIf.winRange = winRange;
  ebwd_window_decoder uDec (.dec(decIf));

  // pin inputs pass two flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      portMeta_reg <= 16'h0000;
      portSync_reg <= 16'h0000;
      readyMeta_reg <= 1'b0;
      readyNSync_reg <= 1'b0;
    end else begin
      portMeta_reg <= firstPortIn;
      portSync_reg <= portMeta_reg;
      readyMeta_reg <= extReadyN;
      readyNSync_reg <= readyMeta_reg;
    end
  end

  // reference clock output divider; bus changes only on its rising edge
  logic halfTick, riseTick;
  assign halfTick = divCnt_reg == (REF_HALF - 8'h01);
  assign riseTick = halfTick && !refClk_reg;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_reg <= 8'h00;
      refClk_reg <= 1'b0;
    end else if (halfTick) begin
      divCnt_reg <= 8'h00;
      refClk_reg <= !refClk_reg;
    end else begin
      divCnt_reg <= divCnt_reg + 8'h01;
    end
  end

  // request classification
  logic accept, isExt, trapNow, undefReg, intNow, busNow, postNow;
  always_comb begin
    accept = reqValid && reqReady_reg;
    isExt = (decIf.region == ebwd_pkg::REGION_EXTMEM) ||
      (decIf.region == ebwd_pkg::REGION_EXTIO);
    trapNow = !reqPeriph && ((decIf.region == ebwd_pkg::REGION_TRAP) ||
      (isExt && singleChipMode));
    undefReg = !reqPeriph && (decIf.region == ebwd_pkg::REGION_FLASHREG) &&
      (reqAddr > FLASHREG_TOP);
    intNow = !reqPeriph && !trapNow && !undefReg && !isExt;
    busNow = reqPeriph || (isExt && !singleChipMode);
    // external memory writes are posted, I/O writes wait for the bus
    postNow = reqWrite && !reqPeriph &&
      (decIf.region == ebwd_pkg::REGION_EXTMEM);
  end

  logic is8, isMux, splitMore, strobeDone, busLast;
  logic [`EBWD_AW-1:0] busAddr;
  logic [`EBWD_DW-1:0] laneData, src;
  logic [1:0] laneOe;
  always_comb begin
    is8 = (curMode_reg == ebwd_pkg::MODE_MUX8) ||
      (curMode_reg == ebwd_pkg::MODE_DEMUX8);
    isMux = (curMode_reg == ebwd_pkg::MODE_MUX8) ||
      (curMode_reg == ebwd_pkg::MODE_MUX16);
    // word on an 8-bit bus runs as low byte then high byte
    splitMore = is8 && !curByte_reg && !curSecond_reg;
    strobeDone = (waitCnt_reg == 4'h0) && !(curRdyEn_reg && readyNSync_reg);
    busLast = (state_reg == ST_HOLD) && riseTick && !splitMore;
    busAddr = {curAddr_reg[`EBWD_AW-1:1],
      curByte_reg ? curAddr_reg[0] : curSecond_reg};
    src = curPeriph_reg ? periphRdata : portSync_reg;
    if (is8) begin
      laneData = {8'h00, curSecond_reg ? curWdata_reg[15:8] :
        curWdata_reg[7:0]};
      laneOe = `EBWD_OE_LOW;
    end else if (curByte_reg) begin
      laneData = {curWdata_reg[7:0], curWdata_reg[7:0]};
      laneOe = curAddr_reg[0] ? `EBWD_OE_HIGH : `EBWD_OE_LOW;
    end else begin
      laneData = curWdata_reg;
      laneOe = `EBWD_OE_ALL;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept && busNow) state_next = ST_ADDR;
        else if (accept && intNow) state_next = ST_INT;
      end
      ST_INT: if (intRespValid) state_next = ST_IDLE;
      ST_ADDR: if (riseTick) state_next = ST_ALE;
      ST_ALE: if (riseTick) state_next = ST_STROBE;
      ST_STROBE: if (riseTick && strobeDone) state_next = ST_HOLD;
      ST_HOLD: if (riseTick) state_next = splitMore ? ST_ADDR : ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      reqReady_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      reqReady_reg <= state_next == ST_IDLE;
    end
  end

  // access latch; window set chosen per access
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      curAddr_reg <= 24'h000000;
      curWrite_reg <= 1'b0;
      curByte_reg <= 1'b0;
      curWdata_reg <= 16'h0000;
      curRegion_reg <= ebwd_pkg::REGION_EXTMEM;
      curWin_reg <= 3'h0;
      curPeriph_reg <= 1'b0;
      curSingle_reg <= 1'b1;
      curMode_reg <= ebwd_pkg::MODE_DEMUX16;
      curWaits_reg <= 4'h0;
      curRdyEn_reg <= 1'b0;
      curPosted_reg <= 1'b0;
      curSecond_reg <= 1'b0;
    end else if (accept) begin
      curAddr_reg <= reqAddr;
      curWrite_reg <= reqWrite;
      curByte_reg <= reqByte;
      curWdata_reg <= reqWdata;
      curRegion_reg <= decIf.region;
      curWin_reg <= decIf.winIdx;
      curPeriph_reg <= reqPeriph;
      curSingle_reg <= singleChipMode;
      curMode_reg <= ebwd_pkg::ebwd_mode_e'(funcCfg[decIf.winIdx]
        [`EBWD_FC_MODE_LSB +: `EBWD_FC_MODE_W]);
      curWaits_reg <= timeCfg[decIf.winIdx];
      curRdyEn_reg <= funcCfg[decIf.winIdx][`EBWD_FC_RDY_BIT];
      curPosted_reg <= postNow;
      curSecond_reg <= 1'b0;
    end else if ((state_reg == ST_HOLD) && riseTick && splitMore) begin
      curSecond_reg <= 1'b1;
    end
  end

  // wait states counted in reference clock periods
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      waitCnt_reg <= 4'h0;
    end else if (riseTick && (state_reg == ST_ALE)) begin
      waitCnt_reg <= curWaits_reg;
    end else if (riseTick && (state_reg == ST_STROBE) &&
      (waitCnt_reg != 4'h0)) begin
      waitCnt_reg <= waitCnt_reg - 4'h1;
    end
  end

  // bus pins; peripheral bus cycles leave the pins alone
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ale_reg <= 1'b0;
      rdN_reg <= 1'b1;
      wrN_reg <= 1'b1;
      bheN_reg <= 1'b1;
      csN_reg <= `EBWD_CS_IDLE;
      firstPortOut_reg <= 16'h0000;
      firstPortOe_reg <= `EBWD_OE_NONE;
      secondPortOut_reg <= 16'h0000;
      segOut_reg <= 7'h00;
    end else if (riseTick && !curPeriph_reg) begin
      case (state_reg)
        ST_ADDR: begin
          csN_reg <= csFor(curWin_reg);
          segOut_reg <= busAddr[`EBWD_SEG_MSB:`EBWD_SEG_LSB] &
            segMask(segLines);
          bheN_reg <= is8 || (curByte_reg && !curAddr_reg[0]);
          ale_reg <= 1'b1;
          if (isMux) begin
            firstPortOut_reg <= busAddr[`EBWD_DW-1:0];
            firstPortOe_reg <= `EBWD_OE_ALL;
          end else begin
            secondPortOut_reg <= busAddr[`EBWD_DW-1:0];
          end
        end
        ST_ALE: begin
          ale_reg <= 1'b0;
          if (curWrite_reg) begin
            firstPortOut_reg <= laneData;
            firstPortOe_reg <= laneOe;
            wrN_reg <= 1'b0;
          end else begin
            firstPortOe_reg <= `EBWD_OE_NONE;
            rdN_reg <= 1'b0;
          end
        end
        ST_STROBE: begin
          if (strobeDone) begin
            rdN_reg <= 1'b1;
            wrN_reg <= 1'b1;
          end
        end
        ST_HOLD: begin
          firstPortOe_reg <= `EBWD_OE_NONE;
          if (!splitMore) csN_reg <= `EBWD_CS_IDLE;
        end
        default: begin
        end
      endcase
    end
  end

  // read data gathered lane by lane
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busRdata_reg <= 16'h0000;
    end else if (riseTick && (state_reg == ST_STROBE) && strobeDone &&
      !curWrite_reg) begin
      if (is8 && curSecond_reg) busRdata_reg[15:8] <= src[7:0];
      else if (is8) busRdata_reg <= {8'h00, src[7:0]};
      else if (curByte_reg)
        busRdata_reg <= {8'h00, curAddr_reg[0] ? src[15:8] : src[7:0]};
      else busRdata_reg <= src;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      respValid_reg <= 1'b0;
      respTrap_reg <= 1'b0;
      respRdata_reg <= 16'h0000;
    end else begin
      respValid_reg <= 1'b0;
      if (accept && (trapNow || undefReg)) begin
        respValid_reg <= 1'b1;
        respTrap_reg <= trapNow;
        respRdata_reg <= undefReg ? TRAP_CODE : 16'h0000;
      end else if (accept && postNow && busNow) begin
        respValid_reg <= 1'b1;
        respTrap_reg <= 1'b0;
        respRdata_reg <= 16'h0000;
      end else if ((state_reg == ST_INT) && intRespValid) begin
        respValid_reg <= 1'b1;
        respTrap_reg <= 1'b0;
        respRdata_reg <= intRdata;
      end else if (busLast && !curPosted_reg) begin
        respValid_reg <= 1'b1;
        respTrap_reg <= 1'b0;
        respRdata_reg <= curWrite_reg ? 16'h0000 : busRdata_reg;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      intReqValid_reg <= 1'b0;
      periphSel_reg <= 1'b0;
      ioOrdered_reg <= 1'b0;
      activeWin_reg <= 3'h0;
    end else begin
      intReqValid_reg <= accept && intNow;
      if (accept && busNow) begin
        periphSel_reg <= reqPeriph;
        ioOrdered_reg <= decIf.region == ebwd_pkg::REGION_EXTIO;
        activeWin_reg <= decIf.winIdx;
      end else if (busLast) begin
        periphSel_reg <= 1'b0;
        ioOrdered_reg <= 1'b0;
      end
    end
  end

  assign reqReady = reqReady_reg;
  assign respValid = respValid_reg;
  assign respTrap = respTrap_reg;
  assign respRdata = respRdata_reg;
  assign intReqValid = intReqValid_reg;
  assign intRegion = curRegion_reg;
  assign intAddr = curAddr_reg;
  assign intWrite = curWrite_reg;
  assign intByte = curByte_reg;
  assign intWdata = curWdata_reg;
  assign periphSel = periphSel_reg;
  assign activeWin = activeWin_reg;
  assign ioOrdered = ioOrdered_reg;
  assign refClkOut = refClk_reg;
  assign ale = ale_reg;
  assign rdN = rdN_reg;
  assign wrN = wrN_reg;
  assign bheN = bheN_reg;
  assign csN = csN_reg;
  assign firstPortOut = firstPortOut_reg;
  assign firstPortOe = firstPortOe_reg;
  assign secondPortOut = secondPortOut_reg;
  assign segOut = segOut_reg;

  trap_answer_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    accept && !reqPeriph && (decIf.region == ebwd_pkg::REGION_TRAP)
    |=> respValid_reg && respTrap_reg)
    else $error("trap region access not answered with a trap");
  flashreg_code_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    accept && undefReg |=> respValid_reg && (respRdata_reg == TRAP_CODE))
    else $error("undefined flash register did not return trap code");
  io_not_posted_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    accept && busNow && (decIf.region == ebwd_pkg::REGION_EXTIO)
    |=> !respValid_reg [*2])
    else $error("external io access answered before the bus cycle");
  demux_addr_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (state_reg == ST_STROBE) && !isMux && !curPeriph_reg
    |-> secondPortOut_reg == busAddr[`EBWD_DW-1:0])
    else $error("demultiplexed address missing on second port");
  mux_addr_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(ale_reg) && isMux |-> (firstPortOut_reg == busAddr[`EBWD_DW-1:0])
    && (firstPortOe_reg == `EBWD_OE_ALL))
    else $error("multiplexed address not driven on first port");
  seg_lines_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(ale_reg) |-> (segOut_reg & ~segMask(segLines)) == 7'h00)
    else $error("inactive segment line driven high");
  default_select_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (state_reg == ST_STROBE) && (curWin_reg == 3'h0) && !curPeriph_reg
    |-> !csN_reg[0])
    else $error("default select not active for unmatched access");
  win4_no_pin_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (state_reg != ST_IDLE) && (curWin_reg == 3'h4)
    |-> csN_reg == `EBWD_CS_IDLE)
    else $error("window 4 access drove a select pin");
  ale_on_rise_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(ale_reg) |-> $rose(refClk_reg))
    else $error("address latch not aligned to reference clock rise");
  single_chip_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (csN_reg != `EBWD_CS_IDLE) |-> !curSingle_reg)
    else $error("select asserted in single-chip mode");
endmodule // ebwd_top

// File: ebwd_params.svh
// constants and field layout of the external bus window decoder
`ifndef EBWD_PARAMS_SVH
`define EBWD_PARAMS_SVH
`define EBWD_AW 24
`define EBWD_DW 16
`define EBWD_NWIN 4
`define EBWD_NSET 5
`define EBWD_INTDATA_LO 24'h008000
`define EBWD_EXTMEM1_LO 24'h010000
`define EBWD_IORSV_LO 24'h200000
`define EBWD_EXTIO_LO 24'h200800
`define EBWD_EXTMEM2_LO 24'h400000
`define EBWD_SEGRSV_LO 24'hbf0000
`define EBWD_FLASH_LO 24'hc00000
`define EBWD_PGRSV_LO 24'hc20000
`define EBWD_PROGRAM_SRAM_LO 24'he00000
`define EBWD_PSRSV_LO 24'he00800
`define EBWD_TRAP_LO 24'hf80000
`define EBWD_FLREG_LO 24'hfff000
`define EBWD_WIN_GRAIN 12
`define EBWD_WR_W 16
`define EBWD_WR_BASE_LSB 4
`define EBWD_WR_SIZE_W 4
`define EBWD_FC_W 3
`define EBWD_FC_MODE_LSB 0
`define EBWD_FC_MODE_W 2
`define EBWD_FC_RDY_BIT 2
`define EBWD_TC_W 4
`define EBWD_SEG_W 7
`define EBWD_SEG_LSB 16
`define EBWD_SEG_MSB 22
`define EBWD_CS_IDLE 4'hf
`define EBWD_OE_NONE 2'h0
`define EBWD_OE_LOW 2'h1
`define EBWD_OE_HIGH 2'h2
`define EBWD_OE_ALL 2'h3
`endif

// File: ebwd_pkg.sv
// types shared by the window decoder and the bus controller
package ebwd_pkg;
  typedef logic [23:0] ebwd_addr_t;
  typedef enum logic [2:0] {
    REGION_EXTMEM, REGION_EXTIO, REGION_INTDATA, REGION_FLASH,
    REGION_PROGRAM_SRAM, REGION_FLASHREG, REGION_TRAP
  } ebwd_region_e;
  typedef enum logic [1:0] {
    MODE_DEMUX16, MODE_MUX16, MODE_MUX8, MODE_DEMUX8
  } ebwd_mode_e;
endpackage

// File: ebwd_dec_if.sv
// signals between the bus controller and the window decoder
`timescale 1ns/1ns
`include "ebwd_params.svh"
interface ebwd_dec_if;
  ebwd_pkg::ebwd_addr_t addr;
  logic [`EBWD_NWIN-1:0] winEnable;
  logic [`EBWD_NWIN-1:0][`EBWD_WR_W-1:0] winRange;
  ebwd_pkg::ebwd_region_e region;
  logic [2:0] winIdx;
  modport requester (output addr, winEnable, winRange, input region, winIdx);
  modport decoder (input addr, winEnable, winRange, output region, winIdx);
endinterface // ebwd_dec_if

// File: ebwd_window_decoder.sv
// address region and address window decoder
`timescale 1ns/1ns
`include "ebwd_params.svh"
module ebwd_window_decoder (
  // decoder end of the request
  ebwd_dec_if.decoder dec
);
  // descending ladder over the 24-bit space
  function automatic ebwd_pkg::ebwd_region_e regionOf(
    input logic [`EBWD_AW-1:0] a);
    if (a >= `EBWD_FLREG_LO) regionOf = ebwd_pkg::REGION_FLASHREG;
    else if (a >= `EBWD_TRAP_LO) regionOf = ebwd_pkg::REGION_TRAP;
    else if (a >= `EBWD_PSRSV_LO) regionOf = ebwd_pkg::REGION_TRAP;
    else if (a >= `EBWD_PROGRAM_SRAM_LO) regionOf = ebwd_pkg::REGION_PROGRAM_SRAM;
    else if (a >= `EBWD_PGRSV_LO) regionOf = ebwd_pkg::REGION_TRAP;
    else if (a >= `EBWD_FLASH_LO) regionOf = ebwd_pkg::REGION_FLASH;
    else if (a >= `EBWD_SEGRSV_LO) regionOf = ebwd_pkg::REGION_TRAP;
    else if (a >= `EBWD_EXTMEM2_LO) regionOf = ebwd_pkg::REGION_EXTMEM;
    else if (a >= `EBWD_EXTIO_LO) regionOf = ebwd_pkg::REGION_EXTIO;
    else if (a >= `EBWD_IORSV_LO) regionOf = ebwd_pkg::REGION_TRAP;
    else if (a >= `EBWD_EXTMEM1_LO) regionOf = ebwd_pkg::REGION_EXTMEM;
    else if (a >= `EBWD_INTDATA_LO) regionOf = ebwd_pkg::REGION_INTDATA;
    else regionOf = ebwd_pkg::REGION_EXTMEM;
  endfunction

  // window = base in 4 Kbyte grains, size code widens it by powers of two
  function automatic logic winHit(input logic [`EBWD_AW-1:0] a,
    input logic [`EBWD_WR_W-1:0] r);
    logic [11:0] mask;
    mask = 12'hfff << r[`EBWD_WR_SIZE_W-1:0];
    winHit = ((a[`EBWD_AW-1:`EBWD_WIN_GRAIN] ^
      r[`EBWD_WR_W-1:`EBWD_WR_BASE_LSB]) & mask) == 12'h000;
  endfunction

  logic [`EBWD_NWIN-1:0] hits;

  // full 24-bit compare covers segment and page alike
  assign dec.region = regionOf(dec.addr);

  genvar g;
  generate
    for (g = 0; g < `EBWD_NWIN; g++) begin : gHit
      assign hits[g] = dec.winEnable[g] && winHit(dec.addr, dec.winRange[g]);
    end
  endgenerate

  // higher window number overrides, no hit falls back to set 0
  always_comb begin
    dec.winIdx = 3'h0;
    for (int i = 0; i < `EBWD_NWIN; i++) begin
      if (hits[i]) dec.winIdx = 3'(i + 1);
    end
  end
endmodule // ebwd_window_decoder

// File: ebwd_bus_model.sv
// behavioural external memory on the first port
`timescale 1ns/1ns
module ebwd_bus_model (
  // bus pins
  input wire logic refClkOut,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic [15:0] firstPortOut,
  output logic [15:0] firstPortIn,
  output logic extReadyN,
  // write capture
  output logic [15:0] lastWdata
);
  logic [1:0] busyCnt = 2'h0;
  // read data while strobed, a changing pattern once released
  assign firstPortIn = rdN ? ({16{refClkOut}} ^ 16'ha5c3) : 16'h5a3c;
  // busy for three falling edges of each strobe, sampled mid-period
  always @(negedge refClkOut) begin
    if (rdN && wrN) busyCnt <= 2'h0;
    else if (busyCnt != 2'h3) busyCnt <= busyCnt + 2'h1;
  end
  assign extReadyN = (!rdN || !wrN) && (busyCnt != 2'h3);
  // bytes of the 8-bit bus arrive low byte first
  always @(posedge wrN) begin
    lastWdata <= {firstPortOut[7:0], lastWdata[15:8]};
  end
endmodule // ebwd_bus_model

// File: testbench.sv
// self-checking bench for the external bus window decoder
`timescale 1ns/1ns
`include "ebwd_params.svh"
module testbench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic reqValid = 1'b0;
  logic [23:0] reqAddr = 24'h000000;
  logic reqWrite = 1'b0;
  logic reqByte = 1'b0;
  logic reqPeriph = 1'b0;
  logic [15:0] reqWdata = 16'h0000;
  logic intRespValid = 1'b0;
  logic [15:0] intRdata = 16'h0000;
  logic [15:0] periphRdata = 16'h0000;
  logic singleChipMode = 1'b0;
  logic [2:0] segLines = 3'h7;
  logic [3:0] winEnable = 4'h0;
  logic [3:0][15:0] winRange = 64'h0100010001000100;
  logic [4:0][2:0] funcCfg = 15'h0000;
  logic [4:0][3:0] timeCfg = 20'h22222;
  logic reqReady, respValid, respTrap, intReqValid, refClkOut, rdN;
  logic extReadyN;
  logic [15:0] respRdata, firstPortIn;
  ebwd_pkg::ebwd_region_e intRegion;
  logic [2:0] activeWin;
  logic [3:0] csN, csSeen;
  logic wrN, ale, bheN, ioOrdered, periphSel, intWrite, intByte;
  logic [15:0] intWdata, firstPortOut, secondPortOut, lastWdata;
  logic [23:0] intAddr;
  logic [1:0] firstPortOe;
  logic [6:0] segOut;
  logic ioSeen, perSeen;
  int strb = 0;
  int aleCyc = 0;
  int n_errors = 0;
  int checks = 0;
  ebwd_top #(.REF_HALF(8'h04)) u_dut (.ref_clk, .rstn, .reqValid, .reqAddr,
    .reqWrite, .reqByte, .reqPeriph, .reqWdata, .reqReady, .respValid,
    .respTrap, .respRdata, .intReqValid, .intRegion, .intAddr, .intWrite,
    .intByte, .intWdata, .intRespValid, .intRdata, .periphSel,
    .periphRdata, .singleChipMode, .segLines, .winEnable, .winRange,
    .funcCfg, .timeCfg, .activeWin, .ioOrdered, .refClkOut, .ale, .rdN,
    .wrN, .bheN, .csN, .firstPortIn, .firstPortOut, .firstPortOe,
    .secondPortOut, .segOut, .extReadyN);
  ebwd_bus_model u_mem (.refClkOut, .rdN, .wrN, .firstPortOut, .firstPortIn,
    .extReadyN, .lastWdata);
  always #50 ref_clk = ~ref_clk;
  // internal memory answers one cycle after each request
  always @(posedge ref_clk) begin
    intRespValid <= intReqValid;
    intRdata <= 16'h1234;
  end
  task automatic chk(string nm, logic [23:0] got, logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one access, read or write as reqWrite is set; records every select level seen until the answer
  task automatic acc(logic [23:0] a);
    @(posedge ref_clk);
    reqAddr <= a;
    reqValid <= 1'b1;
    @(posedge ref_clk);
    reqValid <= 1'b0;
    csSeen = 4'hf;
    strb = 0;
    aleCyc = 0;
    ioSeen = 1'b0;
    perSeen = 1'b0;
    for (int i = 0; i < 300; i++) begin
      if (respValid === 1'b1) break;
      @(posedge ref_clk);
      csSeen &= csN;
      if (wrN === 1'b0) strb++;
      if (ale === 1'b1) aleCyc++;
      ioSeen |= ioOrdered;
      perSeen |= periphSel;
    end
    chk("answer", respValid, 1'b1);
  endtask
  task automatic t_trap();
    logic [23:0] tbl [6] = '{24'h200000, 24'hbf0000, 24'hc20000,
      24'he00800, 24'hf80000, 24'hffefff};
    foreach (tbl[i]) begin
      acc(tbl[i]);
      chk("trap", respTrap, 1'b1);
    end
    acc(24'hfff100);
    chk("flreg data", respRdata, 16'h0001);
    chk("flreg trap", respTrap, 1'b0);
    chk("ready", reqReady, 1'b1);
    $display("test trap done");
  endtask
  task automatic t_int();
    acc(24'h008000);
    chk("region", intRegion, ebwd_pkg::REGION_INTDATA);
    chk("int data", respRdata, 16'h1234);
    chk("int addr", intAddr, 24'h008000);
    // only zeros go to register addresses
    reqWrite <= 1'b1;
    acc(24'h00fffe);
    chk("int write", intWrite, 1'b1);
    chk("int wdata", intWdata, 16'h0000);
    chk("region", intRegion, ebwd_pkg::REGION_INTDATA);
    reqByte <= 1'b1;
    acc(24'h00ffff);
    chk("int byte", intByte, 1'b1);
    chk("int byte addr", intAddr, 24'h00ffff);
    reqWrite <= 1'b0;
    reqByte <= 1'b0;
    acc(24'hc1fffe);
    chk("region", intRegion, ebwd_pkg::REGION_FLASH);
    acc(24'he007fe);
    chk("region", intRegion, ebwd_pkg::REGION_PROGRAM_SRAM);
    $display("test internal done");
  endtask
  task automatic t_ext();
    acc(24'h400000);
    chk("ext data", respRdata, 16'h5a3c);
    chk("ext trap", respTrap, 1'b0);
    chk("default cs", csSeen, 4'he);
    chk("default set", activeWin, 3'h0);
    chk("ext seg", segOut, 7'h40);
    chk("ext bhe", bheN, 1'b0);
    chk("ext not io", ioSeen, 1'b0);
    chk("one address phase", aleCyc, 24'h000008);
    $display("test external done");
  endtask
  task automatic t_win();
    winEnable <= 4'h3;
    acc(24'h010000);
    chk("win 2 over 1", activeWin, 3'h2);
    chk("win 2 cs", csSeen, 4'hb);
    winEnable <= 4'hf;
    funcCfg <= 15'h1000;
    acc(24'h010000);
    chk("win 4 wins", activeWin, 3'h4);
    chk("win 4 no pin", csSeen, 4'hf);
    chk("muxed data", respRdata, 16'h5a3c);
    $display("test windows done");
  endtask
  task automatic t_io();
    winEnable <= 4'h1;
    winRange <= 64'h0100010001002000;
    funcCfg <= 15'h1038;
    timeCfg <= 20'h22202;
    segLines <= 3'h5;
    reqWrite <= 1'b1;
    reqWdata <= 16'hbeef;
    acc(24'h200800);
    reqWrite <= 1'b0;
    chk("io cs", csSeen, 4'hd);
    chk("io set", activeWin, 3'h1);
    chk("io ordered", ioSeen, 1'b1);
    chk("io bytes", lastWdata, 16'hbeef);
    chk("ready stretch", strb, 24'h000030);
    chk("two address phases", aleCyc, 24'h000010);
    chk("io addr", secondPortOut, 16'h0801);
    chk("io data lane", firstPortOut, 16'h00be);
    chk("io lanes off", firstPortOe, 2'h0);
    chk("io bhe", bheN, 1'b1);
    chk("seg masked", segOut, 7'h00);
    $display("test external io done");
  endtask
  task automatic t_single();
    singleChipMode <= 1'b1;
    acc(24'h400000);
    chk("single trap", respTrap, 1'b1);
    chk("single cs", csSeen, 4'hf);
    reqPeriph <= 1'b1;
    periphRdata <= 16'hc0de;
    acc(24'h400000);
    reqPeriph <= 1'b0;
    chk("periph data", respRdata, 16'hc0de);
    chk("periph trap", respTrap, 1'b0);
    chk("periph sel", perSeen, 1'b1);
    chk("periph pins", csSeen, 4'hf);
    $display("test single chip done");
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    t_trap();
    t_int();
    t_ext();
    t_win();
    t_io();
    t_single();
    conclude();
  end
endmodule // testbench
